//--- core/calcr_pkg.sv
// Purpose: Constants and carrier types of the calibration control register bank
// Assumes: APB slave at 32-bit data, one aligned word per register
// Notes: Register byte address is four times the register index
package calcr_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_OFS_REF = 8'h65;
  localparam logic [7:0] IDX_AVG = 8'h68;
  localparam logic [7:0] IDX_STATE = 8'h6A;
  localparam logic [7:0] IDX_PIN = 8'h6B;
  localparam logic [7:0] IDX_SW_TRIG = 8'h6C;
  localparam logic [7:0] IDX_MODE = 8'h70;
  localparam logic [7:0] IDX_IRQ_ST = 8'h71;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h72;
  localparam logic [11:0] ADDR_OFS_REF = {2'h0, IDX_OFS_REF, 2'h0};
  localparam logic [11:0] ADDR_AVG = {2'h0, IDX_AVG, 2'h0};
  localparam logic [11:0] ADDR_STATE = {2'h0, IDX_STATE, 2'h0};
  localparam logic [11:0] ADDR_PIN = {2'h0, IDX_PIN, 2'h0};
  localparam logic [11:0] ADDR_SW_TRIG = {2'h0, IDX_SW_TRIG, 2'h0};
  localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
  localparam logic [11:0] ADDR_IRQ_ST = {2'h0, IDX_IRQ_ST, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_OFS_REF = 8'h01;
  localparam logic [7:0] RST_AVG = 8'h61;
  localparam logic [7:0] RST_PIN = 8'h00;
  localparam logic [7:0] RST_SW_TRIG = 8'h01;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OFFSET_REFERENCE_SELECT_BIT = 2;
  localparam int OFFSET_AVERAGING_DEPTH_LSB = 4;
  localparam int LIN_AVG_LSB = 0;
  localparam int AVG_W = 3;
  localparam int CODE_LSB = 2;
  localparam int HALT_BIT = 1;
  localparam int DONE_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int HW_TRIG_BIT = 0;
  localparam int SW_TRIG_BIT = 0;
  localparam int BG_EN_BIT = 1;
  localparam int EV_DONE = 0;
  localparam int EV_HALT = 1;
  localparam int EV_FAULT = 2;

  // ****************************************
  // Status pin sources
  // ****************************************
  localparam logic [1:0] SEL_DONE = 2'h0;
  localparam logic [1:0] SEL_HALT = 2'h1;
  localparam logic [1:0] SEL_FAULT = 2'h2;
  localparam logic [1:0] SEL_LOW = 2'h3;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic fault;
    logic [2:0] stat_code;
    logic bg_stopped;
    logic foreground_cal_complete;
  } calcr_eng_stat_t;

  typedef struct packed {
    logic background_cal_enable;
    logic offset_reference_select;
    logic [2:0] offset_averaging_depth;
    logic [2:0] linearity_averaging_depth;
    logic cal_trigger;
  } calcr_eng_cfg_t;

endpackage

//--- core/calcr_top.sv
// Purpose: APB register bank for calibration control and status
// Assumes: Engine status inputs run on pclk; trigger pin is asynchronous
// Notes: Read of the interrupt status register clears it
`timescale 1ns/1ps
module calcr_top
  import calcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire calcr_eng_stat_t eng_stat,
  output calcr_eng_cfg_t eng_cfg,
  input wire logic cal_trigger_pin,
  output logic cal_status_pin,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] ofs_ref;
    logic [7:0] avg;
    logic [7:0] pin;
    logic [7:0] sw_trig;
    logic [7:0] mode;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic trig_s1;
    logic trig_s2;
    logic trig_sel;
    logic done;
    logic halted;
    logic fault;
    logic [2:0] code;
    logic stat_pin;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } calcr_state_t;

  calcr_state_t st_reg;
  calcr_state_t st_next;
  logic [2:0] ev;
  logic [7:0] rd_byte;
  logic hit;
  logic done_cmp;
  logic halt_cmp;
  logic apb_setup;
  logic apb_done;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    ev = 3'h0;
    rd_byte = 8'h00;
    hit = 1'b1;
    done_cmp = 1'b0;
    halt_cmp = 1'b0;

    // Trigger pin synchroniser
    st_next.trig_s1 = cal_trigger_pin;
    st_next.trig_s2 = st_reg.trig_s1;

    if (st_reg.pin[HW_TRIG_BIT])
    begin
      st_next.trig_sel = st_reg.trig_s2;
    end
    else
    begin
      st_next.trig_sel = st_reg.sw_trig[SW_TRIG_BIT];
    end

    done_cmp = eng_stat.foreground_cal_complete;
    st_next.done = done_cmp;

    if (st_reg.mode[BG_EN_BIT])
    begin
      halt_cmp = eng_stat.bg_stopped;
    end
    else
    begin
      halt_cmp = eng_stat.foreground_cal_complete;
    end
    st_next.halted = halt_cmp;

    st_next.fault = eng_stat.fault;
    st_next.code = eng_stat.stat_code;

    case (st_reg.pin[SEL_LSB +: 2])
      SEL_DONE:
      begin
        st_next.stat_pin = done_cmp;
      end
      SEL_HALT:
      begin
        st_next.stat_pin = halt_cmp;
      end
      SEL_FAULT:
      begin
        st_next.stat_pin = eng_stat.fault;
      end
      SEL_LOW:
      begin
        st_next.stat_pin = 1'b0;
      end
      default:
      begin
        st_next.stat_pin = 1'b0;
      end
    endcase

    // Rising edges of status flags
    ev[EV_DONE] = st_next.done & ~st_reg.done;
    ev[EV_HALT] = st_next.halted & ~st_reg.halted;
    ev[EV_FAULT] = st_next.fault & ~st_reg.fault;

    // APB address decode and read mux
    case (paddr)
      ADDR_OFS_REF:
      begin
        rd_byte = st_reg.ofs_ref;
      end
      ADDR_AVG:
      begin
        rd_byte = st_reg.avg;
      end
      ADDR_STATE:
      begin
        rd_byte = {3'h0, st_reg.code, st_reg.halted, st_reg.done};
      end
      ADDR_PIN:
      begin
        rd_byte = st_reg.pin;
      end
      ADDR_SW_TRIG:
      begin
        rd_byte = st_reg.sw_trig;
      end
      ADDR_MODE:
      begin
        rd_byte = st_reg.mode;
      end
      ADDR_IRQ_ST:
      begin
        rd_byte = {5'h00, st_reg.irq_st};
      end
      ADDR_IRQ_MASK:
      begin
        rd_byte = {5'h00, st_reg.irq_mask};
      end
      default:
      begin
        rd_byte = 8'h00;
        hit = 1'b0;
      end
    endcase

    // One wait state, answer on second access cycle
    apb_setup = psel & penable & ~st_reg.pready;
    apb_done = psel & penable & st_reg.pready;
    st_next.pready = apb_setup;
    st_next.pslverr = apb_setup & ~hit;
    if (apb_setup)
    begin
      st_next.prdata = {24'h000000, rd_byte};
    end
    else if (apb_done)
    begin
      st_next.prdata = 32'h00000000;
    end

    // Register writes
    if (apb_done && pwrite)
    begin
      case (paddr)
        ADDR_OFS_REF:
        begin
          st_next.ofs_ref = pwdata[7:0];
        end
        ADDR_AVG:
        begin
          st_next.avg = pwdata[7:0];
        end
        ADDR_PIN:
        begin
          st_next.pin = pwdata[7:0];
        end
        ADDR_SW_TRIG:
        begin
          st_next.sw_trig = pwdata[7:0];
        end
        ADDR_MODE:
        begin
          st_next.mode = pwdata[7:0];
        end
        ADDR_IRQ_MASK:
        begin
          st_next.irq_mask = pwdata[2:0];
        end
        default:
        begin
          st_next.mode = st_reg.mode;
        end
      endcase
    end

    // Interrupt status: read clears, new event wins
    if (apb_done && !pwrite && (paddr == ADDR_IRQ_ST))
    begin
      st_next.irq_st = 3'h0;
    end
    st_next.irq_st = st_next.irq_st | ev;
    st_next.irq = |(st_next.irq_st & st_next.irq_mask);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg.ofs_ref <= RST_OFS_REF;
      st_reg.avg <= RST_AVG;
      st_reg.pin <= RST_PIN;
      st_reg.sw_trig <= RST_SW_TRIG;
      st_reg.mode <= RST_MODE;
      st_reg.irq_st <= RST_IRQ;
      st_reg.irq_mask <= RST_IRQ;
      st_reg.trig_s1 <= 1'b0;
      st_reg.trig_s2 <= 1'b0;
      st_reg.trig_sel <= 1'b1;
      st_reg.done <= 1'b0;
      st_reg.halted <= 1'b0;
      st_reg.fault <= 1'b0;
      st_reg.code <= 3'h0;
      st_reg.stat_pin <= 1'b0;
      st_reg.irq <= 1'b0;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.prdata <= 32'h00000000;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign cal_status_pin = st_reg.stat_pin;
  assign irq = st_reg.irq;
  assign eng_cfg.background_cal_enable = st_reg.mode[BG_EN_BIT];
  assign eng_cfg.offset_reference_select = st_reg.ofs_ref[OFFSET_REFERENCE_SELECT_BIT];
  assign eng_cfg.offset_averaging_depth = st_reg.avg[OFFSET_AVERAGING_DEPTH_LSB +: AVG_W];
  assign eng_cfg.linearity_averaging_depth = st_reg.avg[LIN_AVG_LSB +: AVG_W];
  assign eng_cfg.cal_trigger = st_reg.trig_sel;

endmodule // calcr_top

//--- test/calcr_props.sv
// Purpose: Port assertions for the calibration register bank
// Assumes: One pclk domain, asynchronous active-low reset
// Notes: Helper copies track the pin setup and trigger level writes
`timescale 1ns/1ps
module calcr_props
  import calcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire calcr_eng_stat_t eng_stat,
  input wire calcr_eng_cfg_t eng_cfg,
  input wire logic cal_trigger_pin,
  input wire logic cal_status_pin,
  input wire logic irq
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  logic wr_done;
  logic halted_c;
  logic pin_c;
  logic [7:0] pin_h;
  logic sw_h;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr_done = psel && penable && pready && pwrite;
  assign halted_c = eng_cfg.background_cal_enable ? eng_stat.bg_stopped : eng_stat.foreground_cal_complete;
  assign pin_c = (pin_h[2:1] == SEL_DONE) ? eng_stat.foreground_cal_complete : (pin_h[2:1] == SEL_HALT) ?
    halted_c : (pin_h[2:1] == SEL_FAULT) ? eng_stat.fault : 1'b0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_h <= 8'h00;
      sw_h <= 1'b1;
    end
    else if (wr_done)
    begin
      if (paddr == ADDR_PIN)
        pin_h <= pwdata[7:0];
      if (paddr == ADDR_SW_TRIG)
        sw_h <= pwdata[0];
    end
  end
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_one_wait_state: assert property (s_access |=> s_answer)
    else $error("ready not after one wait");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_cfg_reset_val: assert property ($rose(presetn) |-> eng_cfg == 9'h063)
    else $error("config reset value wrong");
  a_status_pin_mux: assert property ($past(presetn) |-> cal_status_pin == $past(pin_c))
    else $error("status pin source wrong");
  a_state_read: assert property (psel && penable && !pready && !pwrite && paddr == ADDR_STATE
    && $past(presetn, 2) |=> prdata[4:0] == {$past(eng_stat.stat_code, 2), $past(halted_c, 2),
    $past(eng_stat.foreground_cal_complete, 2)}) else $error("state read wrong");
  a_trig_soft: assert property ($past(presetn) && !$past(pin_h[0])
    |-> eng_cfg.cal_trigger == $past(sw_h)) else $error("software trigger wrong");
  a_trig_pin: assert property ($past(pin_h[0]) && $past(pin_h[0], 2) && $past(presetn, 3)
    |-> eng_cfg.cal_trigger == $past(cal_trigger_pin, 3)) else $error("pin trigger wrong");
  a_avg_apply: assert property (wr_done && paddr == ADDR_AVG |=>
    {eng_cfg.offset_averaging_depth, eng_cfg.linearity_averaging_depth}
    == $past({pwdata[6:4], pwdata[2:0]})) else $error("averaging depth wrong");
  a_ref_apply: assert property (wr_done && paddr == ADDR_OFS_REF |=>
    eng_cfg.offset_reference_select == $past(pwdata[2])) else $error("reference select wrong");
endmodule // calcr_props
bind calcr_top calcr_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .eng_stat(eng_stat), .eng_cfg(eng_cfg),
  .cal_trigger_pin(cal_trigger_pin), .cal_status_pin(cal_status_pin), .irq(irq));

//--- test/tb_calcr_top.sv
// Purpose: Self-checking bench of the calibration register bank
// Assumes: APB with one wait state, eng_stat driven on pclk
// Notes: Each scenario task drives and judges by itself
`timescale 1ns/1ps
module tb_calcr_top
  import calcr_pkg::*;
;
  // ****************************************
  // Signals, tasks and scenarios
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  calcr_eng_stat_t eng_stat = 6'h00;
  calcr_eng_cfg_t eng_cfg;
  logic cal_trigger_pin = 1'b0;
  logic cal_status_pin;
  logic irq;
  logic [31:0] q;
  logic e;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  calcr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_stat(eng_stat), .eng_cfg(eng_cfg),
    .cal_trigger_pin(cal_trigger_pin), .cal_status_pin(cal_status_pin), .irq(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, {24'h0, x});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic t_regs();
    logic [11:0] ra [6];
    logic [7:0] rv [6];
    logic [7:0] wv [6];
    ra = '{ADDR_OFS_REF, ADDR_AVG, ADDR_PIN, ADDR_SW_TRIG, ADDR_MODE, ADDR_IRQ_MASK};
    rv = '{8'h01, 8'h61, 8'h00, 8'h01, 8'h00, 8'h00};
    wv = '{8'h01, 8'h35, 8'h07, 8'h00, 8'h5A, 8'h05};
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], rv[i]);
      apb(1'b1, ra[i], {24'hFFFFFF, wv[i]});
      rd(ra[i], wv[i]);
      apb(1'b1, ra[i], {24'h0, rv[i]});
    end
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, ADDR_STATE, 32'hFF);
    rd(ADDR_STATE, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_cfg();
    apb(1'b1, ADDR_AVG, 32'h35);
    idle(1);
    chk(eng_cfg.offset_averaging_depth, 32'h3);
    chk(eng_cfg.linearity_averaging_depth, 32'h5);
    apb(1'b1, ADDR_MODE, 32'h02);
    apb(1'b1, ADDR_OFS_REF, 32'h05);
    idle(1);
    chk(eng_cfg.background_cal_enable, 32'h1);
    chk(eng_cfg.offset_reference_select, 32'h1);
    apb(1'b1, ADDR_OFS_REF, 32'h01);
    apb(1'b1, ADDR_MODE, 32'h00);
    idle(1);
    chk(eng_cfg.offset_reference_select, 32'h0);
    $display("t_cfg done");
  endtask
  task automatic t_stat(input logic [5:0] es, input logic bg, input logic [7:0] sx,
    input logic [3:0] px);
    apb(1'b1, ADDR_MODE, {30'h0, bg, 1'b0});
    eng_stat <= es;
    idle(3);
    rd(ADDR_STATE, sx);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, ADDR_PIN, {29'h0, s[1:0], 1'b0});
      idle(2);
      chk(cal_status_pin, px[s]);
    end
    $display("t_stat done");
  endtask
  task automatic t_trig();
    apb(1'b1, ADDR_PIN, 32'h0);
    apb(1'b1, ADDR_SW_TRIG, 32'h0);
    cal_trigger_pin <= 1'b1;
    idle(5);
    chk(eng_cfg.cal_trigger, 32'h0);
    apb(1'b1, ADDR_PIN, 32'h1);
    idle(5);
    chk(eng_cfg.cal_trigger, 32'h1);
    cal_trigger_pin <= 1'b0;
    apb(1'b1, ADDR_SW_TRIG, 32'h1);
    idle(5);
    chk(eng_cfg.cal_trigger, 32'h0);
    apb(1'b1, ADDR_PIN, 32'h0);
    idle(2);
    chk(eng_cfg.cal_trigger, 32'h1);
    $display("t_trig done");
  endtask
  task automatic t_irq();
    eng_stat <= 6'h00;
    idle(3);
    apb(1'b0, ADDR_IRQ_ST, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h02);
    eng_stat <= 6'h20;
    idle(3);
    chk(irq, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h04);
    idle(1);
    chk(irq, 32'h1);
    rd(ADDR_IRQ_ST, 8'h04);
    idle(1);
    chk(irq, 32'h0);
    $display("t_irq done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cfg();
    t_stat(6'h15, 1'b0, 8'h17, 4'b0011);
    t_stat(6'h22, 1'b1, 8'h02, 4'b0110);
    t_stat(6'h01, 1'b1, 8'h01, 4'b0001);
    t_trig();
    t_irq();
    complete_run();
  end
endmodule // tb_calcr_top
